// ---- rtl/tfc_pkg.sv ----
// package of register map, field layout and timing constants for tx frame control
package tfc_pkg;
  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_TX_FRAME_CTRL_LOW = 8'h24;
  localparam logic [7:0] ADDR_TX_FRAME_CTRL_HIGH = 8'h28;
  localparam logic [7:0] ADDR_DELAYED_ACTION_TIME = 8'h2c;
  localparam logic [7:0] ADDR_COMMAND = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h44;
  localparam logic [7:0] ADDR_TX_STAMP = 8'h48;
  localparam logic [7:0] ADDR_RX_STAMP = 8'h4c;
  localparam logic [7:0] ADDR_SYS_TIME = 8'h50;
  localparam logic [7:0] ADDR_INDEX_LOAD = 8'h60;
  // ==========================================================================
  // field layout
  localparam int FRAME_LEN_LSB = 0;
  localparam int FRAME_LEN_W = 10;
  localparam int COARSE_CODE_LSB = 12;
  localparam int COARSE_CODE_W = 4;
  localparam int START_INDEX_LSB = 16;
  localparam int START_INDEX_W = 10;
  localparam int FINE_LEN_LSB = 8;
  localparam int FINE_LEN_W = 8;
  localparam logic [9:0] INDEX_WORKAROUND_LIMIT = 10'h07f;
  localparam logic [9:0] INDEX_WORKAROUND_OFFSET = 10'h080;
  localparam logic [9:0] CRC_OCTETS = 10'h002;
  localparam int FINE_UNIT_SHIFT = 3;
  // ==========================================================================
  // reset values
  localparam logic [31:0] RESET_LOW = 32'h0000_0000;
  localparam logic [31:0] RESET_HIGH = 32'h0000_0000;
  localparam logic [31:0] RESET_TIME = 32'h0000_0000;
  // ==========================================================================
  // commands
  typedef enum logic [3:0] {
    CMD_NONE = 4'h0,
    CMD_DELAYED_SEND = 4'h1,
    CMD_DELAYED_SEND_AFTER_TX_STAMP = 4'h2,
    CMD_DELAYED_SEND_AFTER_RX_STAMP = 4'h3,
    CMD_DELAYED_SEND_THEN_LISTEN = 4'h4,
    CMD_DELAYED_SEND_TX_STAMP_THEN_LISTEN = 4'h5,
    CMD_DELAYED_SEND_RX_STAMP_THEN_LISTEN = 4'h6,
    CMD_DELAYED_LISTEN_AFTER_TX_STAMP = 4'h7,
    CMD_DELAYED_LISTEN_AFTER_RX_STAMP = 4'h8
  } tfc_cmd_e;
  // ==========================================================================
  // timing: system time counts at half of the 499.2 MHz fundamental
  localparam real TIME_UNIT_NS = 4.006410;
  localparam real SYMBOL_16M_NS = 993.59;
  localparam real SYMBOL_64M_NS = 1017.63;
  localparam real CLK_NS = 20.0;
  localparam int TIME_STEP_PER_CLK = int'(CLK_NS / TIME_UNIT_NS);
  localparam int SYMBOL_16M_CYC = int'($floor(SYMBOL_16M_NS / CLK_NS));
  localparam int SYMBOL_64M_CYC = int'($floor(SYMBOL_64M_NS / CLK_NS));
endpackage

// ---- rtl/tfc_ctrl_if.sv ----
// interface carrying a resolved transmit job from the register bank to the sender
`timescale 1ns/10ps
interface tfc_ctrl_if;
  logic start;
  logic [9:0] start_index;
  logic [9:0] octet_count;
  logic [11:0] preamble_symbols;
  logic prf_64m;
  logic busy;
  logic done;
  modport bank(output start, output start_index, output octet_count,
    output preamble_symbols, output prf_64m, input busy, input done);
  modport sender(input start, input start_index, input octet_count,
    input preamble_symbols, input prf_64m, output busy, output done);
endinterface

// ---- rtl/tfc_sender.sv ----
// paces preamble symbols and buffer octets for one transmit job
`timescale 1ns/10ps
module tfc_sender
  import tfc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // job
  tfc_ctrl_if.sender job,
  // buffer read side
  output logic [9:0] buf_addr,
  output logic buf_read,
  output logic in_preamble
);
  typedef enum logic [1:0] {ST_IDLE, ST_PREAMBLE, ST_DATA} tfc_send_e;
  tfc_send_e state;
  logic [11:0] symbols_left;
  logic [9:0] octets_left;
  logic [9:0] sym_timer;
  logic prf_64m;

  // ==========================================================================
  // sequencing
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_IDLE;
      symbols_left <= 12'h000;
      octets_left <= 10'h000;
      sym_timer <= 10'h000;
      buf_addr <= 10'h000;
      buf_read <= 1'b0;
      prf_64m <= 1'b0;
      job.done <= 1'b0;
    end else begin
      buf_read <= 1'b0;
      job.done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (job.start) begin
            state <= ST_PREAMBLE;
            symbols_left <= job.preamble_symbols;
            octets_left <= job.octet_count;
            buf_addr <= job.start_index;
            prf_64m <= job.prf_64m;
            sym_timer <= 10'h000;
          end
        end
        ST_PREAMBLE: begin
          // symbol length differs with pulse repetition setting
          if (sym_timer == (prf_64m ? 10'(SYMBOL_64M_CYC - 1) : 10'(SYMBOL_16M_CYC - 1))) begin
            sym_timer <= 10'h000;
            if (symbols_left <= 12'h001) begin
              state <= ST_DATA;
            end
            symbols_left <= symbols_left - 12'h001;
          end else begin
            sym_timer <= sym_timer + 10'h001;
          end
        end
        ST_DATA: begin
          if (octets_left == 10'h000) begin
            state <= ST_IDLE;
            job.done <= 1'b1;
          end else begin
            buf_read <= 1'b1;
            if (buf_read) begin
              buf_addr <= buf_addr + 10'h001;
            end
            octets_left <= octets_left - 10'h001;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  assign job.busy = (state != ST_IDLE);
  assign in_preamble = (state == ST_PREAMBLE);
endmodule

// ---- rtl/tfc_top.sv ----
// transmit frame control and delayed action time register bank
//
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module tfc_top
  import tfc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  output logic [31:0] RDATA,
  // radio side events (asynchronous)
  input wire logic TX_STAMP_EVENT,
  input wire logic RX_STAMP_EVENT,
  input wire logic PRF_64M,
  // radio enables and buffer read
  output logic TX_ENABLE,
  output logic RX_ENABLE,
  output logic PREAMBLE_ON,
  output logic BUF_READ,
  output logic [9:0] BUF_ADDR
);
  logic [31:0] frame_ctrl_low;
  logic [31:0] frame_ctrl_high;
  logic [31:0] delayed_action_time;
  logic [31:0] sys_time;
  logic [31:0] tx_stamp;
  logic [31:0] rx_stamp;
  logic [31:0] target_time;
  logic [9:0] tx_buffer_start_index;
  logic [1:0] tx_sync;
  logic [1:0] rx_sync;
  logic [1:0] prf_sync;
  logic tx_seen;
  logic rx_seen;
  logic listen_after;
  logic pend_send;
  logic pend_listen;
  logic sent_flag;
  logic buf_read_w;
  logic [9:0] buf_addr_w;
  logic preamble_w;
  logic cmd_write;
  logic target_hit;
  tfc_ctrl_if job();

  // ==========================================================================
  // helpers
  function automatic logic [11:0] preamble_len(input logic [7:0] fine,
                                               input logic [3:0] coarse);
    logic [11:0] r;
    r = 12'h040;
    if (fine != 8'h00) begin
      r = 12'({4'h0, fine} + 12'h001) << FINE_UNIT_SHIFT;
    end else begin
      case (coarse)
        4'h1: r = 12'h040;
        4'h2: r = 12'h400;
        4'h3: r = 12'hfff;
        4'h4: r = 12'h020;
        4'h5: r = 12'h080;
        4'h6: r = 12'h600;
        4'h9: r = 12'h100;
        4'ha: r = 12'h800;
        4'hd: r = 12'h200;
        default: r = 12'h040;
      endcase
    end
    return r;
  endfunction

  function automatic logic reached(input logic [31:0] now, input logic [31:0] tgt);
    logic [31:0] d;
    d = (now & 32'hffff_fffe) - (tgt & 32'hffff_fffe);
    return ~d[31];
  endfunction

  function automatic logic [9:0] corrected_index(input logic [9:0] raw);
    logic [9:0] r;
    r = raw;
    if (raw > INDEX_WORKAROUND_LIMIT) begin
      r = raw - INDEX_WORKAROUND_OFFSET;
    end
    return r;
  endfunction

  function automatic logic [9:0] payload_octets(input logic [9:0] frame_len);
    logic [9:0] r;
    r = 10'h000;
    if (frame_len > CRC_OCTETS) begin
      r = frame_len - CRC_OCTETS;
    end
    return r;
  endfunction

  // ==========================================================================
  // input synchronisers
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_sync <= 2'b00;
      rx_sync <= 2'b00;
      prf_sync <= 2'b00;
      tx_seen <= 1'b0;
      rx_seen <= 1'b0;
    end else begin
      tx_sync <= {tx_sync[0], TX_STAMP_EVENT};
      rx_sync <= {rx_sync[0], RX_STAMP_EVENT};
      prf_sync <= {prf_sync[0], PRF_64M};
      tx_seen <= tx_sync[1];
      rx_seen <= rx_sync[1];
    end
  end

  // ==========================================================================
  // system time, about 4 ns per count
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sys_time <= 32'h0000_0000;
    end else begin
      sys_time <= sys_time + 32'(TIME_STEP_PER_CLK);
    end
  end

  // ==========================================================================
  // stamps latched on rising event edges
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_stamp <= 32'h0000_0000;
      rx_stamp <= 32'h0000_0000;
    end else begin
      if (tx_sync[1] && !tx_seen) begin
        tx_stamp <= sys_time;
      end
      if (rx_sync[1] && !rx_seen) begin
        rx_stamp <= sys_time;
      end
    end
  end

  // ==========================================================================
  // register writes
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      frame_ctrl_low <= RESET_LOW;
      frame_ctrl_high <= RESET_HIGH;
      delayed_action_time <= RESET_TIME;
    end else if (WRITE) begin
      if (ADDR == ADDR_TX_FRAME_CTRL_LOW) begin
        frame_ctrl_low <= WDATA;
      end else if (ADDR == ADDR_TX_FRAME_CTRL_HIGH) begin
        frame_ctrl_high <= WDATA & 32'h0000_ff00;
      end else if (ADDR == ADDR_DELAYED_ACTION_TIME) begin
        delayed_action_time <= WDATA;
      end
    end
  end

  // ==========================================================================
  // start index loaded on read of the index-load address
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_buffer_start_index <= 10'h000;
    end else if (READ && ADDR == ADDR_INDEX_LOAD) begin
      tx_buffer_start_index <=
        corrected_index(frame_ctrl_low[START_INDEX_LSB +: START_INDEX_W]);
    end
  end

  // ==========================================================================
  // command strobe and target reach, shared by several processes
  always_comb begin
    cmd_write = WRITE && (ADDR == ADDR_COMMAND);
    target_hit = reached(sys_time, target_time);
  end

  // ==========================================================================
  // delayed commands
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_send <= 1'b0;
      pend_listen <= 1'b0;
      listen_after <= 1'b0;
      target_time <= 32'h0000_0000;
      sent_flag <= 1'b0;
    end else begin
      // a start still in flight counts as busy
      if (cmd_write && !pend_send && !pend_listen && !job.busy && !job.start) begin
        case (tfc_cmd_e'(WDATA[3:0]))
          CMD_DELAYED_SEND, CMD_DELAYED_SEND_THEN_LISTEN: begin
            pend_send <= 1'b1;
            target_time <= delayed_action_time;
            listen_after <= (WDATA[3:0] == CMD_DELAYED_SEND_THEN_LISTEN);
          end
          CMD_DELAYED_SEND_AFTER_TX_STAMP, CMD_DELAYED_SEND_TX_STAMP_THEN_LISTEN: begin
            pend_send <= 1'b1;
            target_time <= tx_stamp + delayed_action_time;
            listen_after <= (WDATA[3:0] == CMD_DELAYED_SEND_TX_STAMP_THEN_LISTEN);
          end
          CMD_DELAYED_SEND_AFTER_RX_STAMP, CMD_DELAYED_SEND_RX_STAMP_THEN_LISTEN: begin
            pend_send <= 1'b1;
            target_time <= rx_stamp + delayed_action_time;
            listen_after <= (WDATA[3:0] == CMD_DELAYED_SEND_RX_STAMP_THEN_LISTEN);
          end
          CMD_DELAYED_LISTEN_AFTER_TX_STAMP: begin
            pend_listen <= 1'b1;
            target_time <= tx_stamp + delayed_action_time;
          end
          CMD_DELAYED_LISTEN_AFTER_RX_STAMP: begin
            pend_listen <= 1'b1;
            target_time <= rx_stamp + delayed_action_time;
          end
          default: begin
          end
        endcase
      end else if (pend_send && target_hit) begin
        pend_send <= 1'b0;
        sent_flag <= 1'b1;
      end else if (pend_listen && target_hit) begin
        pend_listen <= 1'b0;
      end else begin
        sent_flag <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // job to sender
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      job.start <= 1'b0;
      job.start_index <= 10'h000;
      job.octet_count <= 10'h000;
      job.preamble_symbols <= 12'h000;
      job.prf_64m <= 1'b0;
    end else begin
      job.start <= pend_send && target_hit;
      job.start_index <= tx_buffer_start_index;
      // two crc octets are generated, not read
      job.octet_count <= payload_octets(frame_ctrl_low[FRAME_LEN_LSB +: FRAME_LEN_W]);
      job.preamble_symbols <= preamble_len(frame_ctrl_high[FINE_LEN_LSB +: FINE_LEN_W],
        frame_ctrl_low[COARSE_CODE_LSB +: COARSE_CODE_W]);
      job.prf_64m <= prf_sync[1];
    end
  end

  // ==========================================================================
  // elaboration checks on the field layout and the system time step
  if (START_INDEX_W != $bits(BUF_ADDR)) begin : g_index_width_check
    $error("start index width must match the buffer address");
  end
  if (START_INDEX_LSB + START_INDEX_W > 32) begin : g_index_check
    $error("start index field does not fit the control word");
  end
  if (FRAME_LEN_LSB + FRAME_LEN_W > 32) begin : g_length_check
    $error("frame length field does not fit the control word");
  end
  if (FINE_LEN_LSB + FINE_LEN_W > 32) begin : g_fine_check
    $error("fine length field does not fit the control word");
  end
  if (TIME_STEP_PER_CLK < 1) begin : g_step_check
    $error("system time step per clock must be at least one");
  end

  tfc_sender u_sender (
    .clk(REF_CLK),
    .reset_n(RESET_N),
    .job(job),
    .buf_addr(buf_addr_w),
    .buf_read(buf_read_w),
    .in_preamble(preamble_w)
  );

  // ==========================================================================
  // enables and outputs
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TX_ENABLE <= 1'b0;
      RX_ENABLE <= 1'b0;
      PREAMBLE_ON <= 1'b0;
      BUF_READ <= 1'b0;
      BUF_ADDR <= 10'h000;
    end else begin
      TX_ENABLE <= job.busy || job.start;
      if (pend_listen && target_hit) begin
        RX_ENABLE <= 1'b1;
      end else if (job.done && listen_after) begin
        RX_ENABLE <= 1'b1;
      end else if (cmd_write && WDATA[3:0] == CMD_NONE) begin
        RX_ENABLE <= 1'b0;
      end
      PREAMBLE_ON <= preamble_w;
      BUF_READ <= buf_read_w;
      BUF_ADDR <= buf_addr_w;
    end
  end

  // ==========================================================================
  // register reads
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RDATA <= 32'h0000_0000;
    end else if (READ) begin
      if (ADDR == ADDR_TX_FRAME_CTRL_LOW) begin
        RDATA <= frame_ctrl_low;
      end else if (ADDR == ADDR_TX_FRAME_CTRL_HIGH) begin
        RDATA <= frame_ctrl_high;
      end else if (ADDR == ADDR_DELAYED_ACTION_TIME) begin
        RDATA <= delayed_action_time;
      end else if (ADDR == ADDR_STATUS) begin
        RDATA <= {26'h0, sent_flag, job.busy, RX_ENABLE, listen_after, pend_listen, pend_send};
      end else if (ADDR == ADDR_TX_STAMP) begin
        RDATA <= tx_stamp;
      end else if (ADDR == ADDR_RX_STAMP) begin
        RDATA <= rx_stamp;
      end else if (ADDR == ADDR_SYS_TIME) begin
        RDATA <= sys_time;
      end else if (ADDR == ADDR_INDEX_LOAD) begin
        RDATA <= {22'h0, tx_buffer_start_index};
      end else begin
        RDATA <= 32'h0000_0000;
      end
    end else begin
      RDATA <= 32'h0000_0000;
    end
  end
endmodule

// ---- dv/tfc_chk.sv ----
// checker of the tx frame control bank top ports
`timescale 1ns/10ps
module tfc_chk
  import tfc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESET_N,
  // register port
  input wire logic [7:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WRITE,
  input wire logic READ,
  input wire logic [31:0] RDATA,
  // radio side
  input wire logic TX_STAMP_EVENT,
  input wire logic RX_STAMP_EVENT,
  input wire logic PRF_64M,
  input wire logic TX_ENABLE,
  input wire logic RX_ENABLE,
  input wire logic PREAMBLE_ON,
  input wire logic BUF_READ,
  input wire logic [9:0] BUF_ADDR
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);
  // ==========================================================================
  // shadow of written registers
  logic [31:0] sh_low, sh_high, sh_time;
  logic mapped;
  assign mapped = ADDR inside {ADDR_TX_FRAME_CTRL_LOW, ADDR_TX_FRAME_CTRL_HIGH,
    ADDR_DELAYED_ACTION_TIME, ADDR_COMMAND, ADDR_STATUS, ADDR_TX_STAMP, ADDR_RX_STAMP,
    ADDR_SYS_TIME, ADDR_INDEX_LOAD};
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sh_low <= RESET_LOW;
      sh_high <= RESET_HIGH;
      sh_time <= RESET_TIME;
    end else if (WRITE) begin
      if (ADDR == ADDR_TX_FRAME_CTRL_LOW) sh_low <= WDATA;
      if (ADDR == ADDR_TX_FRAME_CTRL_HIGH) sh_high <= WDATA;
      if (ADDR == ADDR_DELAYED_ACTION_TIME) sh_time <= WDATA;
    end
  end
  // ==========================================================================
  // properties
  property p_idle_rdata;
    !$past(READ) |-> RDATA == 32'h0;
  endproperty
  a_idle_rdata: assert property (p_idle_rdata) else $error("read data not zero when idle");
  property p_unmapped;
    READ && !mapped |=> RDATA == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_time_rd;
    READ && ADDR == ADDR_DELAYED_ACTION_TIME |=> RDATA[31:1] == sh_time[31:1];
  endproperty
  a_time_rd: assert property (p_time_rd) else $error("delayed time readback wrong");
  property p_low_rd;
    READ && ADDR == ADDR_TX_FRAME_CTRL_LOW |=>
      (RDATA & 32'h03ff_f3ff) == (sh_low & 32'h03ff_f3ff);
  endproperty
  a_low_rd: assert property (p_low_rd) else $error("low control readback wrong");
  property p_high_rd;
    READ && ADDR == ADDR_TX_FRAME_CTRL_HIGH |=> RDATA[15:8] == sh_high[15:8];
  endproperty
  a_high_rd: assert property (p_high_rd) else $error("fine length readback wrong");
  property p_pre_in_tx;
    PREAMBLE_ON |-> TX_ENABLE;
  endproperty
  a_pre_in_tx: assert property (p_pre_in_tx) else $error("preamble without transmit");
  property p_pre_min;
    $rose(PREAMBLE_ON) |-> PREAMBLE_ON [*8];
  endproperty
  a_pre_min: assert property (p_pre_min) else $error("preamble too short");
  property p_oct_after;
    BUF_READ |-> !PREAMBLE_ON && TX_ENABLE;
  endproperty
  a_oct_after: assert property (p_oct_after) else $error("octet read during preamble");
  property p_tx_pre;
    $rose(TX_ENABLE) |-> ##[0:3] PREAMBLE_ON;
  endproperty
  a_tx_pre: assert property (p_tx_pre) else $error("no preamble after enable");
  c_tx: cover property ($rose(TX_ENABLE));
  c_rx: cover property ($rose(RX_ENABLE) && !TX_ENABLE);
  c_unmapped: cover property (READ && !mapped);
endmodule

bind tfc_top tfc_chk tfc_chk_inst (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .ADDR(ADDR),
  .WDATA(WDATA), .WRITE(WRITE), .READ(READ), .RDATA(RDATA), .TX_STAMP_EVENT(TX_STAMP_EVENT),
  .RX_STAMP_EVENT(RX_STAMP_EVENT), .PRF_64M(PRF_64M), .TX_ENABLE(TX_ENABLE),
  .RX_ENABLE(RX_ENABLE), .PREAMBLE_ON(PREAMBLE_ON), .BUF_READ(BUF_READ), .BUF_ADDR(BUF_ADDR));

// ---- dv/tfc_host_model.sv ----
// host model driving the register port of the tx frame control bank
`timescale 1ns/10ps
module tfc_host_model
  import tfc_pkg::*;
#(parameter int BUF_DEPTH = 1024)
(
  // clock
  input wire logic clk,
  // register port
  output logic [7:0] addr,
  output logic [31:0] wdata,
  output logic write,
  output logic read,
  input wire logic [31:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 32'h0;
    write = 1'b0;
    read = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clk);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    read <= 1'b1;
    @(posedge clk);
    read <= 1'b0;
    #1;
    d = rdata;
  endtask
  // ==========================================================================
  // frame setup with index workaround and load read
  task automatic cfg(input logic [9:0] idx, input logic [9:0] len, input logic [7:0] fine,
    input logic [3:0] code);
    logic [9:0] w;
    logic [31:0] d;
    w = (idx > INDEX_WORKAROUND_LIMIT) ? idx + INDEX_WORKAROUND_OFFSET : idx;
    if (int'(idx) + int'(len) > BUF_DEPTH) len = 10'(BUF_DEPTH - int'(idx));
    wr(ADDR_TX_FRAME_CTRL_LOW, {6'h0, w, code, 2'h0, len});
    wr(ADDR_TX_FRAME_CTRL_HIGH, {16'h0, fine, 8'h0});
    rd(ADDR_INDEX_LOAD, d);
  endtask
endmodule

// ---- dv/test_tfc_top.sv ----
// self-checking testbench of the tx frame control bank
`timescale 1ns/10ps
module test_tfc_top
  import tfc_pkg::*;
;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic write, read, tx_en, rx_en, pre_on, buf_rd;
  logic tx_ev = 1'b0;
  logic rx_ev = 1'b0;
  logic prf = 1'b0;
  logic [9:0] buf_addr;
  int error_cnt = 0;
  int checks_done = 0;
  always #10 ref_clk = ~ref_clk;
  tfc_top tfc_top_inst (.REF_CLK(ref_clk), .RESET_N(reset_n), .ADDR(addr), .WDATA(wdata),
    .WRITE(write), .READ(read), .RDATA(rdata), .TX_STAMP_EVENT(tx_ev), .RX_STAMP_EVENT(rx_ev),
    .PRF_64M(prf), .TX_ENABLE(tx_en), .RX_ENABLE(rx_en), .PREAMBLE_ON(pre_on),
    .BUF_READ(buf_rd), .BUF_ADDR(buf_addr));
  tfc_host_model tfc_host_model_inst (.clk(ref_clk), .addr(addr), .wdata(wdata),
    .write(write), .read(read), .rdata(rdata));
  // ==========================================================================
  // reporting
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_win(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("MISMATCH %0t wait %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] d;
    tfc_host_model_inst.rd(ADDR_TX_FRAME_CTRL_LOW, d);
    cmp_val(d, RESET_LOW);
    tfc_host_model_inst.rd(ADDR_TX_FRAME_CTRL_HIGH, d);
    cmp_val(d, RESET_HIGH);
    tfc_host_model_inst.rd(ADDR_DELAYED_ACTION_TIME, d);
    cmp_val(d, RESET_TIME);
    tfc_host_model_inst.wr(8'h10, 32'hffff_ffff);
    tfc_host_model_inst.rd(8'h10, d);
    cmp_val(d, 32'h0);
    tfc_host_model_inst.wr(ADDR_DELAYED_ACTION_TIME, 32'ha5c3_0f01);
    tfc_host_model_inst.rd(ADDR_DELAYED_ACTION_TIME, d);
    cmp_val(d & 32'hffff_fffe, 32'ha5c3_0f00);
    $display("t_regs done");
  endtask
  task automatic t_send(input tfc_cmd_e cmd, input logic [9:0] idx, input logic [9:0] len,
    input logic [7:0] fine, input logic [3:0] code, input int sym);
    logic [31:0] now, base, st;
    logic [9:0] first;
    int w, pre, n, k;
    bit tx, lis;
    tx = cmd <= CMD_DELAYED_SEND_RX_STAMP_THEN_LISTEN;
    lis = cmd >= CMD_DELAYED_SEND_THEN_LISTEN;
    tfc_host_model_inst.cfg(idx, len, fine, code);
    base = 32'h0;
    if (cmd inside {4'h2, 4'h5, 4'h7}) tfc_host_model_inst.rd(ADDR_TX_STAMP, base);
    if (cmd inside {4'h3, 4'h6, 4'h8}) tfc_host_model_inst.rd(ADDR_RX_STAMP, base);
    tfc_host_model_inst.rd(ADDR_SYS_TIME, now);
    // odd target: low bit must be dropped
    tfc_host_model_inst.wr(ADDR_DELAYED_ACTION_TIME, now + 32'd801 - base);
    tfc_host_model_inst.wr(ADDR_COMMAND, {28'h0, cmd});
    // a second command while one is pending must be ignored
    tfc_host_model_inst.wr(ADDR_COMMAND, {28'h0, CMD_DELAYED_LISTEN_AFTER_TX_STAMP});
    tfc_host_model_inst.rd(ADDR_STATUS, st);
    cmp_val(st & 32'h3b, tx ? 32'h1 : 32'h2);
    w = 0;
    while (!(tx ? tx_en === 1'b1 : rx_en === 1'b1) && w < 400) begin
      @(posedge ref_clk);
      #1;
      w++;
    end
    k = 801 / TIME_STEP_PER_CLK;
    cmp_win(w, k - 10, k + 2);
    pre = 0;
    n = 0;
    k = 0;
    first = 10'h0;
    while (tx_en === 1'b1 && k < 20000) begin
      if (pre_on === 1'b1) pre++;
      if (buf_rd === 1'b1 && n == 0) first = buf_addr;
      if (buf_rd === 1'b1) n++;
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (tx) begin
      cmp_val(pre, sym * (prf ? SYMBOL_64M_CYC : SYMBOL_16M_CYC));
      cmp_val(n, len - CRC_OCTETS);
      cmp_val(first, idx);
    end
    repeat (3) @(posedge ref_clk);
    #1;
    cmp_val(rx_en, lis);
    cmp_val(tx_en, 1'b0);
    tfc_host_model_inst.wr(ADDR_COMMAND, 32'h0);
    repeat (2) @(posedge ref_clk);
    #1;
    cmp_val(rx_en, 1'b0);
    $display("t_send %0d done", cmd);
  endtask
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    @(posedge ref_clk);
    tx_ev <= 1'b1;
    repeat (10) @(posedge ref_clk);
    rx_ev <= 1'b1;
    repeat (4) @(posedge ref_clk);
    tx_ev <= 1'b0;
    rx_ev <= 1'b0;
    for (int c = 1; c <= 8; c++) t_send(tfc_cmd_e'(c), 10'd5, 10'd6, 8'h01, 4'h0, 16);
    @(posedge ref_clk);
    prf <= 1'b1;
    t_send(CMD_DELAYED_SEND, 10'd200, 10'd4, 8'h00, 4'h4, 32);
    summarize();
  end
  initial begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    summarize();
  end
endmodule
